/* File: include/sarlr_pkg.sv */
// constants and carrier types for the sar converter control and readout
// assumes one system clock at 125 MHz and one readout clock from the far end
package sarlr_pkg;

	// ---------------------------------------------------------------
	// resolution and conversion timing
	// ---------------------------------------------------------------
	localparam int RES_W         = 18;
	localparam int T_CLK_NS      = 8;
	localparam int T_CONV_MIN_NS = 88;
	localparam int T_CONV_MAX_NS = 101;
	localparam int CONV_CYC_MIN  = (T_CONV_MIN_NS + T_CLK_NS - 1) / T_CLK_NS;
	localparam int CONV_CYC_MAX  = T_CONV_MAX_NS / T_CLK_NS;
	// strobe edge is seen two or three cycles after the pin moves
	localparam int SYNC_LAT      = 2;
	localparam int SAR_CYCLES    = CONV_CYC_MIN - SYNC_LAT;
	localparam int FRAME_ONE     = RES_W;
	localparam int FRAME_TWO     = RES_W / 2;
	// arbitrary fixed pattern of 1010 and 0101 nibbles
	localparam logic [RES_W-1:0] TEST_PATTERN = 18'h2a55a;

	// ---------------------------------------------------------------
	// register map
	// ---------------------------------------------------------------
	localparam logic [11:0] ADDR_CTRL   = 12'h000;
	localparam logic [11:0] ADDR_STATUS = 12'h004;
	localparam logic [11:0] ADDR_RESULT = 12'h008;
	localparam int CTRL_PWR_BIT  = 0;
	localparam int CTRL_PAT_BIT  = 1;
	localparam int CTRL_DUAL_BIT = 2;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_VAL_BIT  = 1;
	localparam int STAT_HOLD_BIT = 2;
	localparam logic [2:0] CTRL_RESET = 3'h1;

	// ---------------------------------------------------------------
	// types
	// ---------------------------------------------------------------
	typedef struct packed {
		logic dual_lane_select;
		logic pattern_select;
		logic power_down_n;
	} sarlr_cfg_t;

	typedef enum logic [0:0] {
		ST_IDLE,
		ST_CONV
	} sarlr_state_t;

	typedef struct packed {
		sarlr_cfg_t         cfg;
		logic [2:0]         cnv_s;
		logic               cnv_lvl;
		sarlr_state_t       state;
		logic [3:0]         step;
		logic [RES_W-1:0]   hold;
		logic [RES_W-1:0]   code;
		logic [RES_W-1:0]   result;
		logic               valid;
		logic               hold_out;
		logic               lane_a_en;
		logic               lane_b_en;
		logic               echo_en;
		logic               pready;
		logic               pslverr;
		logic [31:0]        prdata;
	} sarlr_ref_t;

	typedef struct packed {
		logic [2:0]         rst_s;
		logic               rst_lvl;
		sarlr_cfg_t [2:0]   cfg_s;
		sarlr_cfg_t         cfg;
		logic [4:0]         idx;
		logic               lane_a;
		logic               lane_b;
	} sarlr_link_t;

endpackage : sarlr_pkg

/* File: rtl/sarlr_top.sv */
// sar converter control, apb registers and serial lane readout
// assumes an apb master on ref_clk_i and a controller that drives the
// readout clock in whole frames, within the strobe timing windows
//
// Contract
// R1 - power_down_n low shuts all logic and lanes; only conversion, lanes and the echo driver stop here, apb registers stay live
// R2 - pattern_select high sends fixed test pattern
// R3 - dual lane: two bits per clock, A and B
// R4 - single lane: one bit per clock on A
// R5 - single lane: lane B driver disabled
// R6 - controller supplies readout clock, one shift each
// R7 - echo readout clock back beside the data
// R8 - strobe rise enters hold, starts conversion
// R9 - binary search from half down to 1/262144
// R10 - 18-bit result available at conversion end
// R11 - result is two's complement
// R12 - controller may flip MSB for offset binary
// R13 - no latency: readout belongs to same strobe
// R14 - result ready 88 to 101 ns after strobe
// R15 - first readout clock 104 ns after strobe
// R16 - previous frame ends 83 ns after strobe
// R17 - MSB first, eighteen or nine clocks
`timescale 1ns/1ps

module sarlr_top
	import sarlr_pkg::*;
(
	// system clock and reset
	input  wire logic              ref_clk_i,
	input  wire logic              srst_i,
	// apb slave
	input  wire logic              psel_i,
	input  wire logic              penable_i,
	input  wire logic              pwrite_i,
	input  wire logic [11:0]       paddr_i,
	input  wire logic [31:0]       pwdata_i,
	input  wire logic [3:0]        pstrb_i,
	output logic      [31:0]       prdata_o,
	output logic                   pready_o,
	output logic                   pslverr_o,
	// analog front end
	input  wire logic [RES_W-1:0]  analog_code_i,
	output logic                   sample_hold_o,
	// conversion strobe pin
	input  wire logic              convert_strobe_i,
	// readout link
	input  wire logic              link_clk_i,
	output logic                   echo_clock_out_o,
	output logic                   echo_en_o,
	output logic                   lane_a_data_o,
	output logic                   lane_a_en_o,
	output logic                   lane_b_data_o,
	output logic                   lane_b_en_o
);

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	// two comparator decisions per cycle against the held level
	function automatic logic [RES_W-1:0] sar_pair(
		input logic [RES_W-1:0] code,
		input logic [RES_W-1:0] level,
		input logic [3:0]       step
	);
		logic [RES_W-1:0] c;
		logic [RES_W-1:0] trial;
		int               pos;
		c = code;
		for (int k = 0; k < 2; k++) begin
			pos   = RES_W - 1 - 2 * int'(step) - k;
			trial = c | (RES_W'(1) << pos);
			if (level >= trial) begin
				c = trial;
			end
		end
		return c;
	endfunction : sar_pair

	function automatic logic bit_at(
		input logic [RES_W-1:0] word,
		input int               pos
	);
		return word[pos];
	endfunction : bit_at

	// ---------------------------------------------------------------
	// system clock domain
	// ---------------------------------------------------------------
	sarlr_ref_t r_q;
	sarlr_ref_t r_d;
	logic       cnv_rise;
	logic       conv_done;
	logic       apb_take;
	logic       apb_hit;
	logic [31:0] rd_word;

	always_comb begin
		r_d = r_q;
		// first flop feeds only the second
		r_d.cnv_s = {r_q.cnv_s[1:0], convert_strobe_i};
		if (r_q.cnv_s[1] == r_q.cnv_s[2]) begin
			r_d.cnv_lvl = r_q.cnv_s[2];
		end
		cnv_rise  = (r_q.cnv_s[1] == r_q.cnv_s[2]) && r_q.cnv_s[2] && !r_q.cnv_lvl;
		conv_done = (r_q.state == ST_CONV) && (r_q.step == 4'(SAR_CYCLES - 1));

		// apb: one wait state so read data leaves a flop
		apb_take = psel_i && penable_i && !r_q.pready;
		apb_hit  = (paddr_i == ADDR_CTRL) || (paddr_i == ADDR_STATUS)
			|| (paddr_i == ADDR_RESULT);
		rd_word  = 32'h0000_0000;
		unique case (paddr_i)
			ADDR_CTRL: begin
				rd_word[CTRL_PWR_BIT]  = r_q.cfg.power_down_n;
				rd_word[CTRL_PAT_BIT]  = r_q.cfg.pattern_select;
				rd_word[CTRL_DUAL_BIT] = r_q.cfg.dual_lane_select;
			end
			ADDR_STATUS: begin
				rd_word[STAT_BUSY_BIT] = (r_q.state == ST_CONV);
				rd_word[STAT_VAL_BIT]  = r_q.valid;
				rd_word[STAT_HOLD_BIT] = r_q.hold_out;
			end
			ADDR_RESULT: begin
				rd_word[RES_W-1:0] = r_q.result;
			end
			default: begin
				rd_word = 32'h0000_0000;
			end
		endcase
		r_d.pready  = apb_take;
		r_d.pslverr = apb_take && !apb_hit;
		r_d.prdata  = (apb_take && !pwrite_i && apb_hit) ? rd_word : 32'h0000_0000;
		if (psel_i && penable_i && r_q.pready && pwrite_i && pstrb_i[0]
				&& (paddr_i == ADDR_CTRL)) begin
			r_d.cfg.power_down_n     = pwdata_i[CTRL_PWR_BIT];
			r_d.cfg.pattern_select   = pwdata_i[CTRL_PAT_BIT];
			r_d.cfg.dual_lane_select = pwdata_i[CTRL_DUAL_BIT];
		end

		// output drivers follow the mode
		r_d.lane_a_en = r_q.cfg.power_down_n;                                 // R1
		r_d.lane_b_en = r_q.cfg.power_down_n && r_q.cfg.dual_lane_select;     // R5
		r_d.echo_en   = r_q.cfg.power_down_n;                                 // R7

		// conversion sequencer
		unique case (r_q.state)
			ST_IDLE: begin
				if (cnv_rise && r_q.cfg.power_down_n) begin
					r_d.state    = ST_CONV;                                     // R8
					r_d.hold     = analog_code_i;
					r_d.hold_out = 1'b1;
					// first pair decided here, else pin-to-result overruns its window
					r_d.code     = sar_pair('0, analog_code_i, 4'h0);           // R9
					r_d.step     = 4'h1;                                        // R14
				end
			end
			ST_CONV: begin
				r_d.code = sar_pair(r_q.code, r_q.hold, r_q.step);           // R9
				if (conv_done) begin
					r_d.state    = ST_IDLE;
					r_d.hold_out = 1'b0;
					// offset level to two's complement
					r_d.result   = r_d.code ^ {1'b1, {(RES_W-1){1'b0}}};     // R11
					r_d.valid    = 1'b1;                                        // R10
				end else begin
					r_d.step = r_q.step + 4'h1;
				end
			end
		endcase
		// a strobe while converting is ignored; power down aborts
		if (!r_q.cfg.power_down_n) begin
			r_d.state    = ST_IDLE;                                             // R1
			r_d.hold_out = 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			r_q            <= '0;
			r_q.cfg        <= sarlr_cfg_t'(CTRL_RESET);
			r_q.state      <= ST_IDLE;
		end else begin
			r_q <= r_d;
		end
	end

	assign prdata_o      = r_q.prdata;
	assign pready_o      = r_q.pready;
	assign pslverr_o     = r_q.pslverr;
	assign sample_hold_o = r_q.hold_out;
	assign lane_a_en_o   = r_q.lane_a_en;
	assign lane_b_en_o   = r_q.lane_b_en;
	assign echo_en_o     = r_q.echo_en;

	// ---------------------------------------------------------------
	// readout clock domain
	// ---------------------------------------------------------------
	// result word is quasi static: it changes only after the previous
	// frame has ended and before the next one starts, by strobe timing
	sarlr_link_t      l_q;
	sarlr_link_t      l_d;
	logic             run;
	logic [RES_W-1:0] word;
	int               pos_a;

	always_comb begin
		l_d = l_q;
		l_d.rst_s = {l_q.rst_s[1:0], srst_i};
		if (l_q.rst_s[1] == l_q.rst_s[2]) begin
			l_d.rst_lvl = l_q.rst_s[2];
		end
		l_d.cfg_s = {l_q.cfg_s[1:0], r_q.cfg};
		if (l_q.cfg_s[1] == l_q.cfg_s[2]) begin
			l_d.cfg = l_q.cfg_s[2];
		end
		run   = !l_q.rst_lvl && l_q.cfg.power_down_n;
		word  = l_q.cfg.pattern_select ? TEST_PATTERN : r_q.result;          // R2 R13
		pos_a = l_q.cfg.dual_lane_select ? RES_W - 1 - 2 * int'(l_q.idx)
			: RES_W - 1 - int'(l_q.idx);                                     // R17
		if (!run || (l_d.cfg != l_q.cfg)) begin
			l_d.idx    = 5'h00;
			l_d.lane_a = 1'b0;
			l_d.lane_b = 1'b0;
		end else if (l_q.cfg.dual_lane_select) begin
			l_d.lane_a = bit_at(word, pos_a);                                 // R3
			l_d.lane_b = bit_at(word, pos_a - 1);
			l_d.idx    = (l_q.idx == 5'(FRAME_TWO - 1)) ? 5'h00 : l_q.idx + 5'h01;
		end else begin
			l_d.lane_a = bit_at(word, pos_a);                                 // R4
			l_d.lane_b = 1'b0;
			l_d.idx    = (l_q.idx == 5'(FRAME_ONE - 1)) ? 5'h00 : l_q.idx + 5'h01;
		end
	end

	always_ff @(posedge link_clk_i) begin
		l_q <= l_d;
	end

	assign lane_a_data_o = l_q.lane_a;
	assign lane_b_data_o = l_q.lane_b;
	// echo must track the readout clock edge for edge, so no flop here
	assign echo_clock_out_o = link_clk_i;                                      // R7

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	property p_pd_drivers_off;
		@(posedge ref_clk_i) disable iff (srst_i)
		!r_q.cfg.power_down_n |=> !lane_a_en_o && !lane_b_en_o && !echo_en_o;
	endproperty
	a_pd_drivers_off: assert property (p_pd_drivers_off) // R1
		else $error("drivers on during power down");

	property p_pd_no_conv;
		@(posedge ref_clk_i) disable iff (srst_i)
		!r_q.cfg.power_down_n |=> (r_q.state == ST_IDLE) && !sample_hold_o;
	endproperty
	a_pd_no_conv: assert property (p_pd_no_conv) // R1
		else $error("conversion running in power down");

	property p_single_b_off;
		@(posedge ref_clk_i) disable iff (srst_i)
		!r_q.cfg.dual_lane_select |=> !lane_b_en_o;
	endproperty
	a_single_b_off: assert property (p_single_b_off) // R5
		else $error("lane b driver on in single lane mode");

	property p_strobe_hold;
		@(posedge ref_clk_i) disable iff (srst_i)
		cnv_rise && (r_q.state == ST_IDLE) && r_q.cfg.power_down_n
			|=> sample_hold_o && (r_q.hold == $past(analog_code_i));
	endproperty
	a_strobe_hold: assert property (p_strobe_hold) // R8
		else $error("strobe did not enter hold");

	property p_conv_time;
		@(posedge ref_clk_i) disable iff (srst_i || !r_q.cfg.power_down_n)
		cnv_rise && (r_q.state == ST_IDLE) && r_q.cfg.power_down_n
			|=> (r_q.state == ST_CONV)[*7] ##1 conv_done ##1 r_q.valid && !sample_hold_o;
	endproperty
	a_conv_time: assert property (p_conv_time) // R14
		else $error("conversion length wrong");

	property p_result_code;
		@(posedge ref_clk_i) disable iff (srst_i)
		conv_done |=> r_q.result == (r_q.hold ^ {1'b1, {(RES_W-1){1'b0}}});
	endproperty
	a_result_code: assert property (p_result_code) // R11
		else $error("result not two's complement of held level");

	property p_hold_stable;
		@(posedge ref_clk_i) disable iff (srst_i)
		(r_q.state == ST_CONV) |=> $stable(r_q.hold);
	endproperty
	a_hold_stable: assert property (p_hold_stable) // R13
		else $error("held level changed during conversion");

	property p_apb_answer;
		@(posedge ref_clk_i) disable iff (srst_i)
		psel_i && penable_i && !pready_o |=> pready_o ##1 !pready_o;
	endproperty
	a_apb_answer: assert property (p_apb_answer)
		else $error("apb answer not one wait state");

	property p_dual_wrap;
		@(posedge link_clk_i) disable iff (l_q.rst_lvl)
		run && l_q.cfg.dual_lane_select && (l_d.cfg == l_q.cfg)
			&& (l_q.idx == 5'h08) |=> (l_q.idx == 5'h00);
	endproperty
	a_dual_wrap: assert property (p_dual_wrap) // R17
		else $error("dual lane frame not nine clocks");

	property p_single_b_zero;
		@(posedge link_clk_i) disable iff (l_q.rst_lvl)
		run && !l_q.cfg.dual_lane_select |=> !lane_b_data_o;
	endproperty
	a_single_b_zero: assert property (p_single_b_zero) // R4
		else $error("lane b active in single lane mode");

	property p_pattern_msb;
		@(posedge link_clk_i) disable iff (l_q.rst_lvl)
		run && l_q.cfg.pattern_select && (l_d.cfg == l_q.cfg) && (l_q.idx == 5'h00)
			|=> lane_a_data_o == TEST_PATTERN[RES_W-1];
	endproperty
	a_pattern_msb: assert property (p_pattern_msb) // R2
		else $error("test pattern msb missing");

	c_conv_done: cover property (@(posedge ref_clk_i) disable iff (srst_i) conv_done);
	c_apb_write: cover property (@(posedge ref_clk_i) disable iff (srst_i)
		psel_i && penable_i && pready_o && pwrite_i);
	c_dual_frame: cover property (@(posedge link_clk_i) disable iff (l_q.rst_lvl)
		run && l_q.cfg.dual_lane_select && (l_q.idx == 5'h08));
	c_single_frame: cover property (@(posedge link_clk_i) disable iff (l_q.rst_lvl)
		run && !l_q.cfg.dual_lane_select && (l_q.idx == 5'h11));

endmodule : sarlr_top

/* File: tb/sarlr_ctrl_model.sv */
// controller model: conversion strobe, gated readout clock, lane capture
// assumes lanes launch on the rising readout edge and hold until the next
`timescale 1ns/1ps

module sarlr_ctrl_model
	import sarlr_pkg::*;
(
	// system clock
	input  wire logic ref_clk_i,
	// readout link
	input  wire logic echo_i,
	input  wire logic lane_a_i,
	input  wire logic lane_b_i,
	output logic      strobe_o,
	output logic      link_clk_o
);
	int echo_bad;

	initial begin
		strobe_o = 1'b0;
		link_clk_o = 1'b0;
		echo_bad = 0;
	end

	// ---------------------------------------------------------------
	// strobe, then idle long enough before the first readout edge
	// ---------------------------------------------------------------
	task automatic convert();
		@(posedge ref_clk_i) strobe_o <= 1'b1;
		repeat (4) @(posedge ref_clk_i);
		strobe_o <= 1'b0;
		// caller only strobes after its previous frame is complete, except the dual lane align, which strobes four clocks into a frame
		repeat (12) @(posedge ref_clk_i);
	endtask : convert

	// ---------------------------------------------------------------
	// n readout clocks of 48 ns; parked low between frames
	// ---------------------------------------------------------------
	task automatic clocks(input int n, input logic dual, output logic [RES_W-1:0] w);
		w = '0;
		for (int i = 0; i < n; i++) begin
			// rise off the system clock edge so neither domain races the other
			#3;
			link_clk_o = 1'b1;
			#23;
			if (echo_i !== 1'b1) echo_bad++;
			#1;
			link_clk_o = 1'b0;
			#1;
			if (echo_i !== 1'b0) echo_bad++;
			if (dual) w = {w[RES_W-3:0], lane_a_i, lane_b_i};
			else w = {w[RES_W-2:0], lane_a_i};
			#20;
		end
	endtask : clocks
endmodule : sarlr_ctrl_model

/* File: tb/sarlr_top_bench.sv */
// bench for the converter control: apb tasks plus controller model
// assumes the one-wait-state apb slave and the lane timing of the top
`timescale 1ns/1ps

module sarlr_top_bench
	import sarlr_pkg::*;
;
	logic             ref_clk_i, srst_i, psel_i, penable_i, pwrite_i;
	logic [11:0]      paddr_i;
	logic [31:0]      pwdata_i, prdata_o;
	logic             pready_o, pslverr_o, sample_hold_o, strb, lclk, echo;
	logic             echo_en_o, lane_a, lane_a_en_o, lane_b, lane_b_en_o;
	logic [RES_W-1:0] analog_code_i, w;
	logic             hold_q, strb_q;
	int               miscompares, num_checks, t, lat;
	logic [RES_W-1:0] codes [5] = '{18'h00000, 18'h3ffff, 18'h20000, 18'h1ffff, 18'h2a5c3};

	sarlr_top dut (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .psel_i(psel_i),
		.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
		.pwdata_i(pwdata_i), .pstrb_i(4'hf), .prdata_o(prdata_o), .pready_o(pready_o),
		.pslverr_o(pslverr_o), .analog_code_i(analog_code_i),
		.sample_hold_o(sample_hold_o), .convert_strobe_i(strb), .link_clk_i(lclk),
		.echo_clock_out_o(echo), .echo_en_o(echo_en_o), .lane_a_data_o(lane_a),
		.lane_a_en_o(lane_a_en_o), .lane_b_data_o(lane_b), .lane_b_en_o(lane_b_en_o));
	sarlr_ctrl_model mdl (.ref_clk_i(ref_clk_i), .echo_i(echo), .lane_a_i(lane_a),
		.lane_b_i(lane_b), .strobe_o(strb), .link_clk_o(lclk));

	initial begin
		ref_clk_i = 1'b0;
		forever #4 ref_clk_i = ~ref_clk_i;
	end

	// strobe-to-hold-release latency, in system cycles
	always @(posedge ref_clk_i) begin
		if (strb && !strb_q) t = 0;
		else t++;
		if (hold_q && !sample_hold_o) lat = t;
		hold_q = sample_hold_o;
		strb_q = strb;
	end

	// ---------------------------------------------------------------
	// report, compare and bus tasks
	// ---------------------------------------------------------------
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : end_of_test

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string s);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: %s got %h expected %h", $time, s, got, exp);
		end
	endtask : chk

	task automatic stall();
		miscompares++;
		$display("Error at %0t: wait ran out", $time);
		end_of_test();
	endtask : stall

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		int n = 0;
		@(posedge ref_clk_i);
		psel_i <= 1'b1;
		pwrite_i <= wr;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge ref_clk_i) penable_i <= 1'b1;
		do begin
			@(posedge ref_clk_i);
			n++;
		end while (pready_o !== 1'b1 && n < 20);
		if (n >= 20) stall();
		rd = prdata_o;
		err = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask : apb

	task automatic rdchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e,
		input logic ee);
		logic [31:0] rd;
		logic        err;
		apb(1'b0, a, 32'h0, rd, err);
		chk(rd & m, e, "read data");
		chk(32'(err), 32'(ee), "slave error");
	endtask : rdchk

	task automatic set_ctrl(input logic [31:0] v, input logic dual);
		logic [31:0] rd;
		logic        err;
		apb(1'b1, ADDR_CTRL, v, rd, err);
		mdl.clocks(8, dual, w);
	endtask : set_ctrl

	// hunt the lone msb of a negative full-scale result to find the frame start
	task automatic align(input logic dual);
		int n = 0;
		@(posedge ref_clk_i) analog_code_i <= 18'h00000;
		mdl.convert();
		do begin
			mdl.clocks(1, dual, w);
			n++;
		end while ((dual ? w[1] : w[0]) !== 1'b1 && n < 40);
		if (n >= 40) stall();
		mdl.clocks((dual ? FRAME_TWO : FRAME_ONE) - 1, dual, w);
	endtask : align

	task automatic conv_chk(input logic [RES_W-1:0] c, input logic dual);
		@(posedge ref_clk_i) analog_code_i <= c;
		lat = -1;
		mdl.convert();
		num_checks++;
		if (lat * T_CLK_NS < T_CONV_MIN_NS || lat * T_CLK_NS > T_CONV_MAX_NS) begin
			miscompares++;
			$display("Error at %0t: hold latency %0d", $time, lat);
		end
		mdl.clocks(dual ? FRAME_TWO : FRAME_ONE, dual, w);
		chk(32'(w ^ 18'h20000), 32'(c), "lane frame");
		rdchk(ADDR_RESULT, 32'h3ffff, 32'(c ^ 18'h20000), 1'b0);
	endtask : conv_chk

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		{srst_i, psel_i, penable_i, pwrite_i} = 4'h8;
		paddr_i = 12'h000;
		pwdata_i = 32'h0;
		analog_code_i = 18'h00000;
		fork
			repeat (10) @(posedge ref_clk_i);
			mdl.clocks(4, 1'b0, w);
		join
		@(posedge ref_clk_i) srst_i <= 1'b0;
		rdchk(ADDR_CTRL, 32'h7, 32'(CTRL_RESET), 1'b0);
		rdchk(ADDR_STATUS, 32'h2, 32'h0, 1'b0);
		rdchk(12'h00c, 32'hffffffff, 32'h0, 1'b1);
		chk(32'({lane_a_en_o, echo_en_o, lane_b_en_o}), 32'h6, "enables");
		$display("reset test done");
		align(1'b0);
		foreach (codes[i]) conv_chk(codes[i], 1'b0);
		rdchk(ADDR_STATUS, 32'h2, 32'h2, 1'b0);
		set_ctrl(32'h3, 1'b0);
		mdl.clocks(FRAME_ONE - 4, 1'b0, w);
		mdl.clocks(FRAME_ONE, 1'b0, w);
		chk(32'(w), 32'(TEST_PATTERN), "pattern");
		$display("single lane test done");
		set_ctrl(32'h5, 1'b1);
		chk(32'(lane_b_en_o), 32'h1, "lane b enable");
		align(1'b1);
		foreach (codes[i]) conv_chk(codes[i], 1'b1);
		chk(32'(mdl.echo_bad), 32'h0, "echo clock");
		$display("dual lane test done");
		set_ctrl(32'h4, 1'b1);
		chk(32'({lane_a_en_o, echo_en_o, lane_b_en_o}), 32'h0, "enables off");
		mdl.clocks(FRAME_TWO, 1'b1, w);
		chk(32'(w), 32'h0, "lanes off");
		lat = -1;
		mdl.convert();
		chk(32'(lat), 32'hffffffff, "hold in power down");
		$display("power down test done");
		end_of_test();
	end
endmodule : sarlr_top_bench
